// [core/operator_panel_value_entry.sv]
/*
 * Two-button value and text entry editor of the local operator panel.
 * Edits up to eight characters on the top display line with a blinking
 * cursor, a scroll press to change the symbol and an enter press to accept.
 * Assumes button presses arrive already debounced as one-cycle pulses on
 * sys_clk_in, and that the display driver renders display_chars_out.
 */
// Functional notes
// - Eight editable cells for number entry
// - Number edit starts at leftmost cell
// - Character at cursor flashes
// - Scroll steps symbol, cursor stays
// - Enter accepts symbol, cursor moves right
// - Accepted decimal point zeroes cells right
// - Eighth cell accepted ends edit, save screen
// - Accepted left arrow steps cursor back
// - Minus offered only at leftmost cell
// - Exponent marker offered at seventh cell
// - Text uses item length, same key behaviour
// - Text offers letters, digits, dash, slash, space
// - Undisplayable text characters shown as asterisk
`timescale 1ns/1ps
module operator_panel_value_entry
    import panel_entry_pkg::*;
#(
    parameter int BLINK_CYCLES = BLINK_HALF_CYCLES  // Half period of the cursor blink
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // Debounced buttons, one-cycle pulses
    input wire logic scroll_press_in,
    input wire logic enter_press_in,
    // Edit requests from the menu logic
    input wire logic start_number_in,
    input wire logic start_text_in,
    input wire logic [LEN_W-1:0] text_len_in,
    input wire line_t init_chars_in,
    input wire logic save_done_in,
    // Editor status
    output logic editing_out,
    output logic save_screen_out,
    output logic [2:0] cursor_out,
    output logic blink_on_out,
    // Display line and result
    output line_t display_chars_out,
    output line_t result_chars_out,
    output logic result_valid_out
);

    localparam int BLINK_W = $clog2(BLINK_CYCLES + 1);
    localparam logic [BLINK_W-1:0] BLINK_LAST = BLINK_W'(BLINK_CYCLES - 1);

    entry_state_t state_q, state_d;        // Editor state
    line_t buf_q, buf_d;                   // Characters being edited
    line_t loaded;                         // Initial text after asterisk substitution
    line_t filled;                         // Line with cells right of the cursor zeroed
    line_t disp_d;                         // Line with the cursor cell blanked when off
    line_t result_q;                       // Accepted line
    logic [2:0] cursor_q, cursor_d;        // Selected cell
    logic [LEN_W-1:0] len_q, len_d;        // Cells in use for this edit
    logic text_q, text_d;                  // Text entry when high
    logic [7:0] held_q, held_d;            // Character at the cursor before scrolling
    logic [BLINK_W-1:0] blink_cnt_q;       // Blink half-period counter
    logic blink_q;                         // Cursor character visible when high
    logic done_q;                          // Result pulse
    logic [7:0] cur_char;                  // Character under the cursor
    logic starting;                        // An edit begins this cycle
    logic start_text_mode;                 // Mode of the edit that begins
    logic in_edit;                         // Editor is active
    logic take_enter;                      // Enter acted on this cycle
    logic take_scroll;                     // Scroll acted on, enter has priority
    logic is_arrow;                        // Cursor shows the back-step arrow
    logic is_dot;                          // Number entry accepts a decimal point
    logic at_last;                         // Cursor on the last cell in use
    logic finish;                          // Last cell accepted
    logic moved;                           // Cursor moves or edit starts
    logic [LEN_W-1:0] clamp_len;           // Requested text length kept in 1..8

    symbol_step_if step ();

    symbol_stepper u_stepper (
        .step (step)
    );

    // Decode of the button actions
    assign in_edit = (state_q == ST_EDIT);
    assign starting = (state_q == ST_IDLE) && (start_number_in || start_text_in);
    assign start_text_mode = start_text_in && !start_number_in;
    assign cur_char = buf_q[cursor_q];
    assign take_enter = in_edit && enter_press_in;
    // Both buttons in one cycle: enter wins, scroll is dropped
    assign take_scroll = in_edit && scroll_press_in && !enter_press_in;
    assign is_arrow = (cur_char == CH_LARROW);
    assign is_dot = !text_q && (cur_char == CH_DOT);
    assign at_last = ({1'b0, cursor_q} == (len_q - 4'd1));
    assign finish = take_enter && !is_arrow && at_last;
    assign moved = starting || (take_enter && !finish);

    // Text length: zero means one cell, more than eight means eight
    assign clamp_len = (text_len_in == 4'd0) ? 4'd1 :
                       (text_len_in > NUM_LEN) ? NUM_LEN : text_len_in;

    // Stepper sees the character under the cursor
    assign step.cur_char = cur_char;
    assign step.text_mode = text_q;
    assign step.pos = cursor_q;

    // Per-cell load substitution, zero fill and cursor blanking
    generate
        for (genvar i = 0; i < POSITIONS; i++) begin : g_cell
            // Characters outside the offered set show as an asterisk
            assign loaded[i] = char_allowed(init_chars_in[i], start_text_mode, 3'(i)) ?
                               init_chars_in[i] : CH_STAR;
            // Cells right of an accepted point become zero
            assign filled[i] = (3'(i) > cursor_q) ? CH_ZERO : buf_q[i];
            // Cursor cell goes blank in the off half of the blink
            assign disp_d[i] = (in_edit && (3'(i) == cursor_q) && !blink_q) ?
                               CH_SPACE : buf_q[i];
        end
    endgenerate

    // Next line contents
    always_comb begin
        buf_d = buf_q;
        if (starting) begin
            buf_d = loaded;
        end else if (take_enter) begin
            if (is_arrow) begin
                buf_d[cursor_q] = held_q;       // Arrow is not stored
            end else if (is_dot) begin
                buf_d = filled;
            end
        end else if (take_scroll) begin
            buf_d[cursor_q] = step.next_char;
        end
    end

    // Next cursor, mode and length
    always_comb begin
        cursor_d = cursor_q;
        len_d = len_q;
        text_d = text_q;
        if (starting) begin
            cursor_d = FIRST_POS;
            text_d = start_text_mode;
            len_d = start_text_mode ? clamp_len : NUM_LEN;
        end else if (take_enter && is_arrow) begin
            // Back one cell; at the leftmost cell the cursor stays
            cursor_d = (cursor_q == FIRST_POS) ? FIRST_POS : cursor_q - 3'd1;
        end else if (take_enter && !at_last) begin
            cursor_d = cursor_q + 3'd1;
        end
    end

    // Character that the cursor finds on arrival, restored by an arrow
    assign held_d = moved ? buf_d[cursor_d] : held_q;

    // Editor state
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (starting) begin
                    state_d = ST_EDIT;
                end
            end
            ST_EDIT: begin
                if (finish) begin
                    state_d = ST_SAVE;
                end
            end
            ST_SAVE: begin
                if (save_done_in) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Edit registers
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= ST_IDLE;
            buf_q <= '0;
            cursor_q <= FIRST_POS;
            len_q <= NUM_LEN;
            text_q <= 1'b0;
            held_q <= 8'h00;
        end else begin
            state_q <= state_d;
            buf_q <= buf_d;
            cursor_q <= cursor_d;
            len_q <= len_d;
            text_q <= text_d;
            held_q <= held_d;
        end
    end

    // Blink timer; restarts visible on every cursor move so the new cell shows at once
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            blink_cnt_q <= '0;
            blink_q <= 1'b1;
        end else if (moved || !in_edit) begin
            blink_cnt_q <= '0;
            blink_q <= 1'b1;
        end else if (blink_cnt_q == BLINK_LAST) begin
            blink_cnt_q <= '0;
            blink_q <= !blink_q;
        end else begin
            blink_cnt_q <= blink_cnt_q + 1'b1;
        end
    end

    // Output registers; the result is held until the next finished edit
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            display_chars_out <= '0;
            result_q <= '0;
            done_q <= 1'b0;
        end else begin
            display_chars_out <= disp_d;
            result_q <= finish ? buf_q : result_q;
            done_q <= finish;
        end
    end

    assign result_chars_out = result_q;
    assign result_valid_out = done_q;
    assign editing_out = in_edit;
    assign save_screen_out = (state_q == ST_SAVE);
    assign cursor_out = cursor_q;
    assign blink_on_out = blink_q;

    // Checks of the editing behaviour
    property p_num_len;
        @(posedge sys_clk_in) disable iff (rst_in)
        (state_q == ST_IDLE) && start_number_in |=> in_edit && (len_q == NUM_LEN) && !text_q;
    endproperty
    a_num_len: assert property (p_num_len) else $error("number edit not eight cells");

    property p_start_left;
        @(posedge sys_clk_in) disable iff (rst_in)
        starting |=> (cursor_q == FIRST_POS) && blink_q;
    endproperty
    a_start_left: assert property (p_start_left) else $error("edit not started leftmost");

    property p_blink;
        @(posedge sys_clk_in) disable iff (rst_in)
        in_edit && !moved && (blink_cnt_q == BLINK_LAST) |=> (blink_q != $past(blink_q));
    endproperty
    a_blink: assert property (p_blink) else $error("cursor did not toggle");

    property p_scroll_stays;
        @(posedge sys_clk_in) disable iff (rst_in)
        take_scroll |=> $stable(cursor_q) && (buf_q[cursor_q] != $past(cur_char));
    endproperty
    a_scroll_stays: assert property (p_scroll_stays) else $error("scroll misbehaved");

    property p_enter_right;
        @(posedge sys_clk_in) disable iff (rst_in)
        take_enter && !is_arrow && !at_last |=> (cursor_q == $past(cursor_q) + 3'd1) ##1
            (cursor_q != 3'd0 || in_edit);
    endproperty
    a_enter_right: assert property (p_enter_right) else $error("enter did not advance");

    property p_dot_fill;
        @(posedge sys_clk_in) disable iff (rst_in)
        take_enter && is_dot && !at_last |=> (buf_q[POSITIONS-1] == CH_ZERO);
    endproperty
    a_dot_fill: assert property (p_dot_fill) else $error("no zero fill after point");

    property p_finish_save;
        @(posedge sys_clk_in) disable iff (rst_in)
        finish |=> save_screen_out && result_valid_out ##1 !result_valid_out;
    endproperty
    a_finish_save: assert property (p_finish_save) else $error("no save screen");

    property p_arrow_back;
        @(posedge sys_clk_in) disable iff (rst_in)
        take_enter && is_arrow && (cursor_q != FIRST_POS) |=> in_edit &&
            (cursor_q == $past(cursor_q) - 3'd1);
    endproperty
    a_arrow_back: assert property (p_arrow_back) else $error("arrow did not step back");

    property p_minus_left;
        @(posedge sys_clk_in) disable iff (rst_in)
        take_scroll && !text_q && (cursor_q != FIRST_POS) |=> (buf_q[cursor_q] != CH_MINUS);
    endproperty
    a_minus_left: assert property (p_minus_left) else $error("minus offered off left");

    property p_exp_seventh;
        @(posedge sys_clk_in) disable iff (rst_in)
        take_scroll && is_dot && (cursor_q == EXP_POS) |=> (buf_q[EXP_POS] == CH_EXP);
    endproperty
    a_exp_seventh: assert property (p_exp_seventh) else $error("no exponent marker");

    property p_text_len;
        @(posedge sys_clk_in) disable iff (rst_in)
        starting && start_text_mode && (text_len_in == 4'd3) |=> text_q && (len_q == 4'd3);
    endproperty
    a_text_len: assert property (p_text_len) else $error("text length not taken");

    property p_text_set;
        @(posedge sys_clk_in) disable iff (rst_in)
        take_scroll && text_q && (cur_char == CH_NINE) |=> (buf_q[cursor_q] == CH_MINUS);
    endproperty
    a_text_set: assert property (p_text_set) else $error("dash missing after nine");

    property p_star;
        @(posedge sys_clk_in) disable iff (rst_in)
        starting && start_text_mode && (init_chars_in[1] >= 8'h61) && (init_chars_in[1] <= 8'h7a)
            |=> (buf_q[1] == CH_STAR);
    endproperty
    a_star: assert property (p_star) else $error("undisplayable not starred");

    property p_wrap;
        @(posedge sys_clk_in) disable iff (rst_in)
        take_scroll && text_q && is_arrow |=> (buf_q[cursor_q] == CH_A);
    endproperty
    a_wrap: assert property (p_wrap) else $error("text set did not wrap");

endmodule : operator_panel_value_entry

// [core/panel_entry_pkg.sv]
/*
 * Shared constants, types and the symbol-set check for the two-button
 * value and text entry editor of the local operator panel.
 * Assumes ASCII character codes on the display line and a 100 MHz clock.
 */
package panel_entry_pkg;

    // Geometry of the editable top line
    localparam int POSITIONS = 8;             // Editable character cells
    localparam int LEN_W = 4;                 // Width of a length count 0..8
    localparam logic [2:0] FIRST_POS = 3'd0;  // Leftmost cell, where edits start
    localparam logic [2:0] EXP_POS = 3'd6;    // Seventh cell takes the exponent marker
    localparam logic [LEN_W-1:0] NUM_LEN = 4'd8;  // Number entry always uses all cells

    // Character codes
    localparam logic [7:0] CH_MINUS = 8'h2d;
    localparam logic [7:0] CH_DOT = 8'h2e;
    localparam logic [7:0] CH_SLASH = 8'h2f;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [7:0] CH_EIGHT = 8'h38;
    localparam logic [7:0] CH_NINE = 8'h39;
    localparam logic [7:0] CH_A = 8'h41;
    localparam logic [7:0] CH_EXP = 8'h45;
    localparam logic [7:0] CH_Y = 8'h59;
    localparam logic [7:0] CH_Z = 8'h5a;
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_STAR = 8'h2a;
    localparam logic [7:0] CH_LARROW = 8'h7f;  // Glyph code of the back-step arrow

    // Cursor blink timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int BLINK_HALF_MS = 250;
    localparam int BLINK_HALF_CYCLES = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;

    // Editor states, Gray along idle -> edit -> save
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EDIT = 2'b01,
        ST_SAVE = 2'b11
    } entry_state_t;

    // One line of characters, cell 0 in the low byte
    typedef logic [POSITIONS-1:0][7:0] line_t;

    // True when the symbol belongs to the set offered at this cell
    function automatic logic char_allowed(input logic [7:0] c, input logic text_mode,
                                          input logic [2:0] pos);
        logic digit;
        digit = (c >= CH_ZERO) && (c <= CH_NINE);
        if (text_mode) begin
            char_allowed = digit || ((c >= CH_A) && (c <= CH_Z)) || (c == CH_MINUS) ||
                           (c == CH_SLASH) || (c == CH_SPACE);
        end else begin
            char_allowed = digit || (c == CH_DOT) || ((c == CH_MINUS) && (pos == FIRST_POS)) ||
                           ((c == CH_EXP) && (pos == EXP_POS));
        end
    endfunction : char_allowed

endpackage : panel_entry_pkg

// [core/symbol_step_if.sv]
/*
 * Carrier between the editor and its symbol stepper: the character under
 * the cursor, the mode and cell, and the symbol that one scroll gives.
 * Assumes both ends sit in the same clock domain; the path is combinational.
 */
`timescale 1ns/1ps
interface symbol_step_if;
    logic [7:0] cur_char;   // Character shown at the cursor
    logic text_mode;        // High for text entry, low for number entry
    logic [2:0] pos;        // Cursor cell
    logic [7:0] next_char;  // Symbol after one scroll press

    modport editor (output cur_char, output text_mode, output pos, input next_char);
    modport stepper (input cur_char, input text_mode, input pos, output next_char);
endinterface : symbol_step_if

// [core/symbol_stepper.sv]
/*
 * Symbol stepper: gives the next symbol of the scroll sequence for the
 * character under the cursor. Purely combinational.
 * Assumes the editor registers whatever it takes from next_char.
 */
`timescale 1ns/1ps
module symbol_stepper
    import panel_entry_pkg::*;
(
    // Link to the editor
    symbol_step_if.stepper step
);

    logic [7:0] c;            // Current symbol
    logic [7:0] after_dot;    // Number symbol that follows the decimal point
    logic [7:0] num_next;     // Next symbol in number entry
    logic [7:0] text_next;    // Next symbol in text entry
    logic known;              // Current symbol is part of the offered set

    assign c = step.cur_char;
    assign known = char_allowed(c, step.text_mode, step.pos);
    // Minus only at the leftmost cell, exponent only at the seventh
    assign after_dot = (step.pos == FIRST_POS) ? CH_MINUS :
                       (step.pos == EXP_POS) ? CH_EXP : CH_LARROW;

    // Number order: 0..9 . (-) (E) arrow, then back to 0
    always_comb begin
        if (!known) begin
            num_next = CH_ZERO;               // Unknown or arrow restarts the set
        end else if ((c >= CH_ZERO) && (c <= CH_EIGHT)) begin
            num_next = c + 8'h01;
        end else if (c == CH_NINE) begin
            num_next = CH_DOT;
        end else if (c == CH_DOT) begin
            num_next = after_dot;
        end else begin
            num_next = CH_LARROW;             // After minus or exponent marker
        end
    end

    // Text order: A..Z 0..9 - / space arrow, then back to A
    always_comb begin
        if (!known) begin
            text_next = CH_A;
        end else if (((c >= CH_A) && (c <= CH_Y)) || ((c >= CH_ZERO) && (c <= CH_EIGHT))) begin
            text_next = c + 8'h01;
        end else if (c == CH_Z) begin
            text_next = CH_ZERO;
        end else if (c == CH_NINE) begin
            text_next = CH_MINUS;
        end else if (c == CH_MINUS) begin
            text_next = CH_SLASH;
        end else if (c == CH_SLASH) begin
            text_next = CH_SPACE;
        end else begin
            text_next = CH_LARROW;            // After space
        end
    end

    assign step.next_char = step.text_mode ? text_next : num_next;

endmodule : symbol_stepper

// [tb/panel_operator_model.sv]
/*
 * Behavioural operator at the panel: presses scroll or enter as asked.
 * Assumes one press is a one-cycle pulse on the editor clock; back to back
 * presses are allowed, so a run of n presses holds the line n cycles.
 */
`timescale 1ns/1ps
module panel_operator_model (
    // Clock from the bench
    input wire logic clk_in,
    // Debounced buttons towards the editor
    output logic scroll_out,
    output logic enter_out
);
    // Both buttons released at time zero
    initial begin
        scroll_out = 1'b0;
        enter_out = 1'b0;
    end

    // Press one button n times in a row, changing lines just after an edge
    task automatic press(input bit use_enter, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_in);
            if (use_enter) begin
                enter_out <= 1'b1;
            end else begin
                scroll_out <= 1'b1;
            end
        end
        @(posedge clk_in);
        enter_out <= 1'b0;
        scroll_out <= 1'b0;
    endtask : press
endmodule : panel_operator_model

// [tb/operator_panel_value_entry_tb_top.sv]
/*
 * Self-checking bench of the panel value entry editor.
 * Assumes the operator model drives the buttons; lines are written as
 * strings reversed, since cell 0 sits in the low byte.
 */
`timescale 1ns/1ps
module operator_panel_value_entry_tb_top;
    import panel_entry_pkg::*;

    logic sys_clk_in = 1'b0;  // 100 MHz clock
    logic rst_in = 1'b1;  // Held for four cycles
    logic start_number_in = 1'b0;
    logic start_text_in = 1'b0;
    logic [LEN_W-1:0] text_len_in = 4'h8;
    line_t init_chars_in = '0;
    logic save_done_in = 1'b0;
    logic scroll_press_in, enter_press_in, editing_out, save_screen_out, blink_on_out;
    logic result_valid_out;
    logic [2:0] cursor_out;
    line_t display_chars_out, result_chars_out;
    int fails = 0;
    int check_count = 0;

    always #5 sys_clk_in = ~sys_clk_in;

    // Short blink so the flashing is seen within a few cycles
    operator_panel_value_entry #(.BLINK_CYCLES(4)) dut (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .scroll_press_in(scroll_press_in),
        .enter_press_in(enter_press_in), .start_number_in(start_number_in),
        .start_text_in(start_text_in), .text_len_in(text_len_in),
        .init_chars_in(init_chars_in), .save_done_in(save_done_in),
        .editing_out(editing_out), .save_screen_out(save_screen_out),
        .cursor_out(cursor_out), .blink_on_out(blink_on_out),
        .display_chars_out(display_chars_out), .result_chars_out(result_chars_out),
        .result_valid_out(result_valid_out));

    panel_operator_model op (.clk_in(sys_clk_in), .scroll_out(scroll_press_in),
        .enter_out(enter_press_in));

    // Compare one value and count it
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Pulse one start line with the given initial line
    task automatic start_edit(input bit text, input line_t init, input logic [3:0] len);
        @(posedge sys_clk_in);
        init_chars_in <= init;
        text_len_in <= len;
        if (text) begin
            start_text_in <= 1'b1;
        end else begin
            start_number_in <= 1'b1;
        end
        @(posedge sys_clk_in);
        start_text_in <= 1'b0;
        start_number_in <= 1'b0;
        #1;
    endtask : start_edit

    // Press a button and check where the cursor ended up
    task automatic keys(input bit use_enter, input int n, input logic [2:0] pos);
        op.press(use_enter, n);
        #1;
        chk(cursor_out, pos);
    endtask : keys

    // Last enter: save screen and result pulse, then leave the save screen
    task automatic finish_edit(input line_t exp, input logic [63:0] mask);
        op.press(1'b1, 1);
        #1;
        chk({save_screen_out, editing_out, result_valid_out}, 3'b101);
        chk(result_chars_out & mask, exp & mask);
        @(posedge sys_clk_in);
        save_done_in <= 1'b1;
        @(posedge sys_clk_in);
        save_done_in <= 1'b0;
        #1;
        chk(save_screen_out, 1'b0);
    endtask : finish_edit

    // Number walk: -0000022 becomes 000011.2
    task automatic number_walk();
        bit seen_on;
        bit seen_off;
        start_edit(1'b0, "2200000-", 4'h8);
        chk({editing_out, cursor_out}, 4'h8);
        seen_on = 0;
        seen_off = 0;
        // The resting cursor cell must show its symbol, then a blank
        repeat (12) begin
            @(negedge sys_clk_in);
            if (blink_on_out === 1'b1 && display_chars_out[0] === CH_MINUS) seen_on = 1;
            if (blink_on_out === 1'b0 && display_chars_out[0] === CH_SPACE) seen_off = 1;
        end
        chk({seen_on, seen_off}, 2'b11);
        keys(1'b0, 2, 3'h0);
        keys(1'b1, 4, 3'h4);
        keys(1'b0, 1, 3'h4);
        keys(1'b1, 1, 3'h5);
        keys(1'b0, 1, 3'h5);
        keys(1'b1, 1, 3'h6);
        keys(1'b0, 8, 3'h6);
        keys(1'b1, 1, 3'h7);
        keys(1'b0, 2, 3'h7);
        finish_edit("2.110000", '1);
    endtask : number_walk

    // Minus at cell 0 only, back-step, exponent at the seventh cell
    task automatic number_marks();
        start_edit(1'b0, "00000000", 4'h8);
        keys(1'b0, 11, 3'h0);
        keys(1'b1, 1, 3'h1);
        keys(1'b0, 11, 3'h1);
        keys(1'b1, 1, 3'h0);
        keys(1'b1, 6, 3'h6);
        keys(1'b0, 11, 3'h6);
        keys(1'b1, 1, 3'h7);
        finish_edit("0E00000-", '1);
    endtask : number_marks

    // Text of three cells: wrap past the arrow, asterisk for lower case, slash
    task automatic text_entry();
        start_edit(1'b1, "     9a/", 4'h3);
        repeat (2) @(posedge sys_clk_in);
        #1;
        chk(display_chars_out[1], CH_STAR);
        keys(1'b0, 3, 3'h0);
        keys(1'b1, 1, 3'h1);
        keys(1'b0, 1, 3'h1);
        keys(1'b1, 1, 3'h2);
        keys(1'b0, 2, 3'h2);
        finish_edit("/AA", 64'h0000_0000_00ff_ffff);
    endtask : text_entry

    // Text length zero is kept to one cell, so one enter finishes
    task automatic text_short();
        start_edit(1'b1, "       A", 4'h0);
        finish_edit("A", 64'h0000_0000_0000_00ff);
    endtask : text_short

    // Print the counts and the verdict, then stop
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    // Main sequence
    initial begin
        repeat (4) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        number_walk();
        number_marks();
        text_entry();
        text_short();
        finish_test();
    end

    // Watchdog: the tests need well under two hundred cycles
    initial begin
        #50us;
        fails++;
        finish_test();
    end
endmodule : operator_panel_value_entry_tb_top
